// [common/pmc_pkg.sv]
// Shared constants, field layouts and types of the motor control core.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
package pmc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int T_RST_MIN_NS = 2000;
   localparam int T_PWM0_NS = 51000;
   localparam int T_PWM1_NS = 204000;
   localparam int T_PWM2_NS = 816000;
   localparam int T_SERVO_MID_NS = 1500000;
   localparam int T_SERVO_SPAN_NS = 500000;
   localparam int T_TACH_GATE_NS = 10000000;
   localparam int TX_BAUD = 9600;
   localparam int SERVO_STEPS = 512;
   localparam int SERVO_TICK_CYC = T_SERVO_SPAN_NS / (SERVO_STEPS * CLK_NS);
   localparam int SERVO_CENTER = T_SERVO_MID_NS / (SERVO_TICK_CYC * CLK_NS);
   // ----------------------------------------------------------------
   // Selections and protocol
   // ----------------------------------------------------------------
   localparam logic [1:0] SRC_ANALOG = 2'h0;
   localparam logic [1:0] SRC_SERVO = 2'h1;
   localparam logic [1:0] SRC_SERIAL = 2'h2;
   localparam logic [1:0] FB_NONE = 2'h0;
   localparam logic [1:0] FB_POS = 2'h1;
   localparam logic [1:0] FB_SPEED = 2'h2;
   localparam logic [7:0] START_BYTE = 8'h80;
   localparam logic [7:0] DEV_TYPE = 8'h00;
   localparam logic [5:0] MOTOR_ALL = 6'h00;
   localparam logic [5:0] MOTOR_CFG = 6'h3f;
   localparam logic [9:0] MID_LEVEL = 10'h200;
   localparam int DUTY_LIM = 1023;
   localparam int CMD_LIM = 511;
   localparam int RATE_EXP_W = 3;
   // ----------------------------------------------------------------
   // Configuration indices written by the serial config command
   // ----------------------------------------------------------------
   localparam logic [3:0] CFG_P_MULT = 4'h0;
   localparam logic [3:0] CFG_P_SHIFT = 4'h1;
   localparam logic [3:0] CFG_I_MULT = 4'h2;
   localparam logic [3:0] CFG_I_SHIFT = 4'h3;
   localparam logic [3:0] CFG_D_MULT = 4'h4;
   localparam logic [3:0] CFG_D_SHIFT = 4'h5;
   localparam logic [3:0] CFG_RATE = 4'h6;
   localparam logic [3:0] CFG_PWM = 4'h7;
   localparam logic [3:0] CFG_DIR_REV = 4'h8;
   localparam logic [3:0] CFG_MOTOR = 4'h9;

   typedef struct packed {
      logic [6:0] p_mult;
      logic [3:0] p_shift;
      logic [6:0] i_mult;
      logic [3:0] i_shift;
      logic [6:0] d_mult;
      logic [3:0] d_shift;
      logic [6:0] loop_rate_setting;
      logic [1:0] pwm_period_select;
      logic dir_rev;
      logic [5:0] motor_num;
   } pmc_cfg_s;

   localparam pmc_cfg_s CFG_RESET = '{p_mult: 7'h08, p_shift: 4'h3, i_mult: 7'h00,
      i_shift: 4'h0, d_mult: 7'h00, d_shift: 4'h0, loop_rate_setting: 7'h00,
      pwm_period_select: 2'h0, dir_rev: 1'b0, motor_num: 6'h00};

   typedef struct packed {
      logic dir;
      logic [6:0] speed;
   } pmc_ser_cmd_s;

   typedef enum logic [3:0] {
      RX_IDLE = 4'h1,
      RX_MEAS = 4'h2,
      RX_DATA = 4'h4,
      RX_STOP = 4'h8
   } pmc_rx_e;
endpackage

// [hdl/pmc_core.sv]
// Motor control core: command decode, feedback capture, PID loop, PWM and diagnostics.
// Assumes level samples come from on-chip converters on i_clk; pins are asynchronous.
//
// Contract
// - Reset held low returns every register to its power-up value.
// - One command source is active, chosen by a static select input.
// - Analog level mid-scale means stop; below reverse, above forward.
// - Servo pulse of 1.5 ms stops; longer forward, shorter reverse.
// - Serial receiver finds its own bit rate, about 2000 to 60000 baud.
// - Diagnostic bytes with feedback and fault flags go out on serial output.
// - Feedback mode none, position or speed sets how commands are read.
// - PID runs only with feedback; otherwise command drives motor directly.
// - Loop error is target minus measured feedback.
// - Position feedback is a 10-bit unsigned level.
// - Speed feedback is a 10-bit tachometer frequency count.
// - Output is P times error plus I times sum plus D times change.
// - Each gain is multiplier then arithmetic right shift.
// - Loop period is PWM period times (bits 6-3 plus one) times 2^bits 2-0.
// - PWM period codes 0, 1, 2 give 51, 204, 816 us.
// - All gains, shifts, loop rate and PWM period are set over serial.
// - Forward drives positive terminal unless direction reversal is set.
// - Serial frames are 8N1, non-inverted.
// - Command opens with 0x80 then type 0x00; others ignored till next start.
// - Byte 3 bit 0 is direction, bits 1-6 motor number 0 or own.
// - Speed 0x00 off to 0x7F full; position mode zero speed holds or disables.
module pmc_core #(
   parameter int PWM_CYC0 = pmc_pkg::T_PWM0_NS / pmc_pkg::CLK_NS,
   parameter int PWM_CYC1 = pmc_pkg::T_PWM1_NS / pmc_pkg::CLK_NS,
   parameter int PWM_CYC2 = pmc_pkg::T_PWM2_NS / pmc_pkg::CLK_NS,
   parameter int TACH_GATE_CYC = pmc_pkg::T_TACH_GATE_NS / pmc_pkg::CLK_NS,
   parameter int TX_BIT_CYC = 1000000000 / (pmc_pkg::TX_BAUD * pmc_pkg::CLK_NS)
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [1:0] i_src_sel,
   input wire logic [1:0] i_fb_mode,
   input wire logic [9:0] i_cmd_level,
   input wire logic [9:0] i_fb_level,
   input wire logic i_servo,
   input wire logic i_tach,
   input wire logic i_rx,
   output logic o_tx,
   output logic o_drive_pos,
   output logic o_drive_neg
);
   import pmc_pkg::*;

   function automatic int clamp(input int v, input int lim);
      clamp = (v > lim) ? lim : ((v < -lim) ? -lim : v);
   endfunction

   function automatic logic [16:0] pwm_len(input logic [1:0] sel);
      case (sel)
         2'h1: pwm_len = 17'(PWM_CYC1);
         2'h2: pwm_len = 17'(PWM_CYC2);
         default: pwm_len = 17'(PWM_CYC0);
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam logic [6:0] SYNC_RST = 7'h01;
   logic [6:0] s1_q, s2_q;
   logic servo_prev_q, tach_prev_q, rx_prev_q;
   logic [1:0] src, fbm;
   logic servo_s, tach_s, rx_s;
   assign {src, fbm, servo_s, tach_s, rx_s} = s2_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s1_q <= SYNC_RST;
         s2_q <= SYNC_RST;
         {servo_prev_q, tach_prev_q, rx_prev_q} <= 3'h1;
      end else begin
         s1_q <= {i_src_sel, i_fb_mode, i_servo, i_tach, i_rx};
         s2_q <= s1_q;
         {servo_prev_q, tach_prev_q, rx_prev_q} <= {servo_s, tach_s, rx_s};
      end
   end

   pmc_cfg_s cfg_q;
   pmc_ser_cmd_s ser_q;

   // ----------------------------------------------------------------
   // PWM timebase and loop tick
   // ----------------------------------------------------------------
   logic [16:0] pwm_cnt_q, thr_q;
   logic [11:0] lp_cnt_q, lp_len;
   logic [9:0] duty_q;
   logic dir_q, pwm_wrap, tick;
   logic [26:0] thr_full;
   assign pwm_wrap = pwm_cnt_q >= pwm_len(cfg_q.pwm_period_select) - 17'h1;
   assign lp_len = (12'h1 + 12'(cfg_q.loop_rate_setting[6:RATE_EXP_W]))
      << cfg_q.loop_rate_setting[RATE_EXP_W-1:0];
   assign tick = pwm_wrap && (lp_cnt_q >= lp_len - 12'h1);
   assign thr_full = duty_q * pwm_len(cfg_q.pwm_period_select);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pwm_cnt_q <= '0;
         lp_cnt_q <= '0;
         thr_q <= '0;
         o_drive_pos <= 1'b0;
         o_drive_neg <= 1'b0;
      end else begin
         pwm_cnt_q <= pwm_wrap ? '0 : pwm_cnt_q + 17'h1;
         if (pwm_wrap) begin
            lp_cnt_q <= tick ? '0 : lp_cnt_q + 12'h1;
            // Duty is latched per period so a change never makes a runt pulse.
            thr_q <= thr_full[26:10];
         end
         o_drive_pos <= (pwm_cnt_q < thr_q) && (dir_q ^ cfg_q.dir_rev);
         o_drive_neg <= (pwm_cnt_q < thr_q) && !(dir_q ^ cfg_q.dir_rev);
      end
   end

   // ----------------------------------------------------------------
   // Servo pulse width and tachometer frequency
   // ----------------------------------------------------------------
   logic [6:0] srv_pre_q;
   logic [11:0] srv_cnt_q, srv_w_q;
   logic [19:0] gate_q;
   logic [9:0] tach_cnt_q, tach_meas_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         srv_pre_q <= '0;
         srv_cnt_q <= '0;
         srv_w_q <= 12'(SERVO_CENTER);
         gate_q <= '0;
         tach_cnt_q <= '0;
         tach_meas_q <= '0;
      end else begin
         srv_pre_q <= (srv_pre_q >= 7'(SERVO_TICK_CYC - 1) || !servo_s) ? '0 : srv_pre_q + 7'h1;
         if (!servo_s) begin
            srv_cnt_q <= '0;
         end else if (srv_pre_q >= 7'(SERVO_TICK_CYC - 1) && srv_cnt_q != '1) begin
            srv_cnt_q <= srv_cnt_q + 12'h1;
         end
         if (servo_prev_q && !servo_s) begin
            srv_w_q <= srv_cnt_q;
         end
         gate_q <= (gate_q >= 20'(TACH_GATE_CYC - 1)) ? '0 : gate_q + 20'h1;
         if (gate_q >= 20'(TACH_GATE_CYC - 1)) begin
            tach_meas_q <= tach_cnt_q;
            tach_cnt_q <= '0;
         end else if (tach_s && !tach_prev_q && tach_cnt_q != '1) begin
            tach_cnt_q <= tach_cnt_q + 10'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Auto-baud serial receiver
   // ----------------------------------------------------------------
   // The first byte after lock loss must be the start byte: its low run from
   // the start bit through bit 6 is eight bit times, which sets the bit period.
   pmc_rx_e rx_q;
   logic [15:0] bit_q;
   logic [19:0] tmr_q;
   logic [2:0] idx_q;
   logic [7:0] sh_q, byte_q;
   logic lock_q, bvld_q, ferr_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rx_q <= RX_IDLE;
         bit_q <= '0;
         tmr_q <= '0;
         idx_q <= '0;
         sh_q <= '0;
         byte_q <= '0;
         lock_q <= 1'b0;
         bvld_q <= 1'b0;
         ferr_q <= 1'b0;
      end else begin
         bvld_q <= 1'b0;
         case (rx_q)
            RX_IDLE: begin
               if (rx_prev_q && !rx_s) begin
                  rx_q <= lock_q ? RX_DATA : RX_MEAS;
                  tmr_q <= lock_q ? 20'(bit_q) + 20'(bit_q[15:1]) : '0;
                  idx_q <= '0;
               end
            end
            RX_MEAS: begin
               tmr_q <= tmr_q + 20'h1;
               if (rx_s) begin
                  bit_q <= 16'((tmr_q + 20'h1) >> 3);
                  lock_q <= 1'b1;
                  byte_q <= START_BYTE;
                  bvld_q <= 1'b1;
                  rx_q <= RX_IDLE;
               end else if (tmr_q == '1) begin
                  rx_q <= RX_IDLE;
               end
            end
            RX_DATA: begin
               tmr_q <= tmr_q - 20'h1;
               if (tmr_q == '0) begin
                  sh_q <= {rx_s, sh_q[7:1]};
                  idx_q <= idx_q + 3'h1;
                  tmr_q <= 20'(bit_q) - 20'h1;
                  if (idx_q == 3'h7) begin
                     rx_q <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               tmr_q <= tmr_q - 20'h1;
               if (tmr_q == '0) begin
                  rx_q <= RX_IDLE;
                  if (rx_s) begin
                     byte_q <= sh_q;
                     bvld_q <= 1'b1;
                  end else begin
                     // A framing error means the rate is wrong; relearn it.
                     lock_q <= 1'b0;
                     ferr_q <= 1'b1;
                  end
               end
            end
            default: rx_q <= RX_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Command parser and configuration
   // ----------------------------------------------------------------
   logic [2:0] ps_q;
   logic cfg_sel_q;
   logic [3:0] cfg_idx_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ps_q <= '0;
         cfg_sel_q <= 1'b0;
         cfg_idx_q <= '0;
         cfg_q <= CFG_RESET;
         ser_q <= '0;
      end else if (bvld_q) begin
         if (byte_q[7]) begin
            ps_q <= (byte_q == START_BYTE) ? 3'h1 : 3'h0;
         end else begin
            case (ps_q)
               3'h1: ps_q <= (byte_q == DEV_TYPE) ? 3'h2 : 3'h0;
               3'h2: begin
                  cfg_sel_q <= byte_q[6:1] == MOTOR_CFG;
                  ser_q.dir <= ((byte_q[6:1] == MOTOR_ALL || byte_q[6:1] == cfg_q.motor_num)
                     && byte_q[6:1] != MOTOR_CFG) ? byte_q[0] : ser_q.dir;
                  ps_q <= (byte_q[6:1] == MOTOR_CFG || byte_q[6:1] == MOTOR_ALL
                     || byte_q[6:1] == cfg_q.motor_num) ? 3'h3 : 3'h0;
               end
               3'h3: begin
                  cfg_idx_q <= byte_q[3:0];
                  if (!cfg_sel_q) begin
                     ser_q.speed <= byte_q[6:0];
                  end
                  ps_q <= cfg_sel_q ? 3'h4 : 3'h0;
               end
               3'h4: begin
                  ps_q <= '0;
                  case (cfg_idx_q)
                     CFG_P_MULT: cfg_q.p_mult <= byte_q[6:0];
                     CFG_P_SHIFT: cfg_q.p_shift <= byte_q[3:0];
                     CFG_I_MULT: cfg_q.i_mult <= byte_q[6:0];
                     CFG_I_SHIFT: cfg_q.i_shift <= byte_q[3:0];
                     CFG_D_MULT: cfg_q.d_mult <= byte_q[6:0];
                     CFG_D_SHIFT: cfg_q.d_shift <= byte_q[3:0];
                     CFG_RATE: cfg_q.loop_rate_setting <= byte_q[6:0];
                     CFG_PWM: cfg_q.pwm_period_select <= byte_q[1:0];
                     CFG_DIR_REV: cfg_q.dir_rev <= byte_q[0];
                     CFG_MOTOR: cfg_q.motor_num <= byte_q[5:0];
                     default: ;
                  endcase
               end
               default: ps_q <= '0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Command value and PID step
   // ----------------------------------------------------------------
   int cmd, tgt, meas, err, acc_n, pid_n;
   logic loop_off;
   logic signed [11:0] err_prev_q;
   logic signed [10:0] acc_q, pid_q;
   logic sat_q;

   always_comb begin
      case (src)
         SRC_SERVO: cmd = clamp(int'(srv_w_q) - SERVO_CENTER, CMD_LIM);
         SRC_SERIAL: cmd = ser_q.dir ? int'(ser_q.speed) * 4 : -int'(ser_q.speed) * 4;
         default: cmd = int'(i_cmd_level) - int'(MID_LEVEL);
      endcase
      // Position targets span the full level range; speed targets are magnitudes.
      if (fbm == FB_POS) begin
         tgt = (src == SRC_SERIAL) ? int'(ser_q.speed) * 8 : cmd + int'(MID_LEVEL);
         meas = int'(i_fb_level);
      end else begin
         tgt = (cmd < 0) ? -cmd : cmd;
         meas = int'(tach_meas_q);
      end
      loop_off = src == SRC_SERIAL && fbm == FB_POS && ser_q.dir && ser_q.speed == '0;
      err = tgt - meas;
      acc_n = clamp(int'(acc_q) + err, DUTY_LIM);
      // The derivative is divided by the loop period's power of two only.
      pid_n = ((int'(cfg_q.p_mult) * err) >>> cfg_q.p_shift)
         + ((int'(cfg_q.i_mult) * acc_n) >>> cfg_q.i_shift)
         + (((int'(cfg_q.d_mult) * (err - int'(err_prev_q))) >>> cfg_q.d_shift)
         >>> cfg_q.loop_rate_setting[RATE_EXP_W-1:0]);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         err_prev_q <= '0;
         acc_q <= '0;
         pid_q <= '0;
         sat_q <= 1'b0;
      end else if (tick && fbm != FB_NONE && !loop_off) begin
         err_prev_q <= 12'(err);
         acc_q <= 11'(acc_n);
         pid_q <= 11'(clamp(pid_n, DUTY_LIM));
         sat_q <= pid_n > DUTY_LIM || pid_n < -DUTY_LIM;
      end else if (fbm == FB_NONE || loop_off) begin
         err_prev_q <= '0;
         acc_q <= '0;
         pid_q <= '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         duty_q <= '0;
         dir_q <= 1'b1;
      end else begin
         case (fbm)
            FB_POS: begin
               duty_q <= 10'(pid_q < 0 ? -int'(pid_q) : int'(pid_q));
               dir_q <= pid_q >= 0;
            end
            FB_SPEED: begin
               duty_q <= 10'(pid_q < 0 ? 0 : int'(pid_q));
               dir_q <= cmd >= 0;
            end
            default: begin
               duty_q <= 10'(clamp((cmd < 0 ? -cmd : cmd) * 2, DUTY_LIM));
               dir_q <= cmd >= 0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Diagnostic transmitter
   // ----------------------------------------------------------------
   // One byte per loop tick; ticks that arrive mid-frame are skipped.
   logic [9:0] tx_sh_q;
   logic [3:0] tx_n_q;
   logic [13:0] tx_tmr_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tx_sh_q <= '1;
         tx_n_q <= '0;
         tx_tmr_q <= '0;
         o_tx <= 1'b1;
      end else if (tx_n_q == '0) begin
         o_tx <= 1'b1;
         if (tick) begin
            tx_sh_q <= {1'b1, sat_q, ferr_q, 6'(meas >> 4), 1'b0};
            tx_n_q <= 4'ha;
            tx_tmr_q <= '0;
         end
      end else begin
         o_tx <= tx_sh_q[0];
         tx_tmr_q <= (tx_tmr_q >= 14'(TX_BIT_CYC - 1)) ? '0 : tx_tmr_q + 14'h1;
         if (tx_tmr_q >= 14'(TX_BIT_CYC - 1)) begin
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_n_q <= tx_n_q - 4'h1;
         end
      end
   end
endmodule

// [tb/pmc_core_chk.sv]
// Port checker of the motor control core, attached by bind.
// Assumes a serial output bit of 8 clocks and a longest PWM period of PWM_CYC2.
module pmc_core_chk #(
   parameter int PWM_CYC2 = 160,
   parameter int TX_BIT_CYC = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [1:0] i_src_sel,
   input wire logic [1:0] i_fb_mode,
   input wire logic [9:0] i_cmd_level,
   input wire logic [9:0] i_fb_level,
   input wire logic i_servo,
   input wire logic i_tach,
   input wire logic i_rx,
   input wire logic o_tx,
   input wire logic o_drive_pos,
   input wire logic o_drive_neg
);
   timeunit 1ns;
   timeprecision 1ps;
   import pmc_pkg::*;
   logic [15:0] settle_q;
   logic [15:0] tx_lo_q;
   logic [15:0] run_q;
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   // Four long periods cover the pin syncs and the duty latch at period end.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || i_src_sel != SRC_ANALOG || i_fb_mode != FB_NONE ||
            !$stable(i_cmd_level)) begin
         settle_q <= 16'h0000;
      end else if (settle_q != 16'hffff) begin
         settle_q <= settle_q + 16'h0001;
      end
   end
   always_ff @(posedge i_clk) begin
      tx_lo_q <= (!i_rst_n || o_tx) ? 16'h0000 : tx_lo_q + 16'h0001;
   end
   always_ff @(posedge i_clk) begin
      run_q <= (!i_rst_n || !(o_drive_pos || o_drive_neg)) ? 16'h0000 : run_q + 16'h0001;
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   property p_reset_idle;
      disable iff (1'b0) !i_rst_n |=> o_tx && !o_drive_pos && !o_drive_neg;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("outputs busy in reset");
   property p_release;
      $rose(i_rst_n) |-> (o_tx && !o_drive_pos && !o_drive_neg) [*8];
   endproperty
   a_release: assert property (p_release) else $error("outputs busy after reset");
   property p_no_both;
      !(o_drive_pos && o_drive_neg);
   endproperty
   a_no_both: assert property (p_no_both) else $error("both terminals driven");
   property p_analog_stop;
      settle_q > 16'(4 * PWM_CYC2) && i_cmd_level == MID_LEVEL |-> !o_drive_pos && !o_drive_neg;
   endproperty
   a_analog_stop: assert property (p_analog_stop) else $error("drive at stop level");
   property p_full_on;
      settle_q > 16'(4 * PWM_CYC2) && i_cmd_level == 10'h3ff && !(o_drive_pos || o_drive_neg)
         |-> ##[1:2] (o_drive_pos || o_drive_neg);
   endproperty
   a_full_on: assert property (p_full_on) else $error("full command gap too long");
   property p_tx_bits;
      $rose(o_tx) |-> tx_lo_q % 16'(TX_BIT_CYC) == 16'h0000 && tx_lo_q <= 16'(9 * TX_BIT_CYC);
   endproperty
   a_tx_bits: assert property (p_tx_bits) else $error("tx low run bad");
   property p_tx_high;
      $rose(o_tx) |-> o_tx [*8];
   endproperty
   a_tx_high: assert property (p_tx_high) else $error("tx high run short");
   property p_run_limit;
      run_q < 16'(PWM_CYC2);
   endproperty
   a_run_limit: assert property (p_run_limit) else $error("drive longer than period");
endmodule

bind pmc_core pmc_core_chk #(.PWM_CYC2(PWM_CYC2), .TX_BIT_CYC(TX_BIT_CYC)) u_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_src_sel(i_src_sel), .i_fb_mode(i_fb_mode),
   .i_cmd_level(i_cmd_level), .i_fb_level(i_fb_level), .i_servo(i_servo), .i_tach(i_tach),
   .i_rx(i_rx), .o_tx(o_tx), .o_drive_pos(o_drive_pos), .o_drive_neg(o_drive_neg));

// [tb/pmc_host_model.sv]
// Host model: sends framed serial commands and makes a tachometer wave.
// Assumes the bench clock; every pin change lands on a falling edge.
module pmc_host_model (
   input wire logic i_clk,
   output logic o_rx,
   output logic o_tach
);
   timeunit 1ns;
   timeprecision 1ps;
   import pmc_pkg::*;
   int bit_cyc = 20;
   int tach_half = 0;
   int tach_cnt = 0;
   initial o_rx = 1'b1;
   initial o_tach = 1'b0;
   // One constant rate per byte, low start, LSB first, one stop bit.
   task automatic send_byte(input logic [7:0] b, input logic stop_ok);
      logic [9:0] f;
      f = {stop_ok, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge i_clk);
         o_rx = f[i];
         repeat (bit_cyc - 1) @(negedge i_clk);
      end
      @(negedge i_clk);
      o_rx = 1'b1;
      repeat (bit_cyc) @(negedge i_clk);
   endtask
   // The start byte opens every command, then type, number and speed.
   task automatic cmd(input logic [7:0] kind, input logic [7:0] b3, input logic [7:0] b4);
      send_byte(START_BYTE, 1'b1);
      send_byte(kind, 1'b1);
      send_byte(b3, 1'b1);
      send_byte(b4, 1'b1);
   endtask
   task automatic cfg(input logic [3:0] idx, input logic [7:0] val);
      cmd(DEV_TYPE, {1'b0, MOTOR_CFG, 1'b1}, {4'h0, idx});
      send_byte(val, 1'b1);
   endtask
   // A zero half period stops the wave so it cannot disturb other modes.
   always @(negedge i_clk) begin
      tach_cnt <= (tach_cnt + 1 >= tach_half) ? 0 : tach_cnt + 1;
      if (tach_half > 0 && tach_cnt == 0) begin
         o_tach <= ~o_tach;
      end
   end
endmodule

// [tb/tb_top.sv]
// Self-checking bench of the motor control core with a host model on its pins.
// Assumes shortened PWM, gate and serial output counts; the servo pin stays idle.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pmc_pkg::*;
   localparam int P0 = 40;
   localparam int P2 = 160;
   localparam int TXB = 8;
   localparam int GATE = 2000;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_servo = 1'b0;
   logic [1:0] i_src_sel = SRC_SERIAL;
   logic [1:0] i_fb_mode = FB_NONE;
   logic [9:0] i_cmd_level = MID_LEVEL;
   logic [9:0] i_fb_level = 10'h000;
   logic i_rx;
   logic i_tach;
   logic o_tx;
   logic o_drive_pos;
   logic o_drive_neg;
   int errors = 0;
   int checks_done = 0;
   logic [31:0] seed = 32'h0b0dd24e;
   always #5 i_clk = ~i_clk;
   pmc_core #(.PWM_CYC0(P0), .PWM_CYC1(2 * P0), .PWM_CYC2(P2), .TACH_GATE_CYC(GATE),
      .TX_BIT_CYC(TXB)) uut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_src_sel(i_src_sel), .i_fb_mode(i_fb_mode),
      .i_cmd_level(i_cmd_level), .i_fb_level(i_fb_level), .i_servo(i_servo), .i_tach(i_tach),
      .i_rx(i_rx), .o_tx(o_tx), .o_drive_pos(o_drive_pos), .o_drive_neg(o_drive_neg));
   pmc_host_model host (.i_clk(i_clk), .o_rx(i_rx), .o_tach(i_tach));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic int mag(input int v);
      return v < 0 ? -v : v;
   endfunction
   function automatic int hi_cyc(input int duty, input int per);
      return (duty > 1023 ? 1023 : duty) * per / 1024;
   endfunction
   task automatic report_and_stop();
      if (errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask
   // Counting over whole periods makes the result independent of phase.
   task automatic expect_drive(input int per, input int v, input int duty);
      int np;
      int nn;
      np = 0;
      nn = 0;
      repeat (3 * per + 8) @(negedge i_clk);
      repeat (4 * per) begin
         @(negedge i_clk);
         np += (o_drive_pos === 1'b1) ? 1 : 0;
         nn += (o_drive_neg === 1'b1) ? 1 : 0;
      end
      check(np, v > 0 ? 4 * hi_cyc(duty, per) : 0);
      check(nn, v < 0 ? 4 * hi_cyc(duty, per) : 0);
   endtask
   task automatic tx_byte_is(input logic [7:0] exp);
      int q;
      logic [7:0] b;
      q = 0;
      for (int i = 0; i < 2000 && q < 10 * TXB; i++) begin
         @(negedge i_clk);
         q = (o_tx === 1'b1) ? q + 1 : 0;
      end
      for (int i = 0; i < 400 && o_tx !== 1'b0; i++) begin
         @(negedge i_clk);
      end
      if (q < 10 * TXB || o_tx !== 1'b0) begin
         check(0, 1);
         report_and_stop();
      end
      repeat (TXB + TXB / 2) @(negedge i_clk);
      for (int i = 0; i < 8; i++) begin
         b[i] = o_tx;
         repeat (TXB) @(negedge i_clk);
      end
      check(b, exp);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      int c;
      logic [9:0] lvl;
      logic [6:0] spd;
      int per[3];
      per = '{P0, 2 * P0, P2};
      repeat (8) @(posedge i_clk);
      @(negedge i_clk);
      i_rst_n = 1'b1;
      check(o_tx, 1'b1);
      host.bit_cyc = 16 + int'(rnd() % 16);
      host.cfg(CFG_P_SHIFT, 8'h02);
      host.cmd(DEV_TYPE, 8'h01, 8'h7f);
      expect_drive(P0, 1, 1016);
      spd = 7'(rnd() % 127 + 1);
      host.cmd(DEV_TYPE, 8'h00, {1'b0, spd});
      host.cmd(8'h05, 8'h01, 8'h7f);
      host.cmd(DEV_TYPE, 8'h0b, 8'h7f);
      expect_drive(P0, -1, 8 * spd);
      host.cfg(CFG_DIR_REV, 8'h01);
      host.cmd(DEV_TYPE, 8'h01, 8'h40);
      expect_drive(P0, -1, 512);
      host.cfg(CFG_DIR_REV, 8'h00);
      for (int k = 0; k < 3; k++) begin
         host.cfg(CFG_PWM, 8'(k));
         expect_drive(per[k], 1, 512);
      end
      // A low stop bit drops the learned rate; the next start byte teaches a new one.
      host.send_byte(8'h55, 1'b0);
      host.bit_cyc = 20 + int'(rnd() % 16);
      host.cmd(DEV_TYPE, 8'h00, 8'h10);
      expect_drive(P2, -1, 128);
      @(negedge i_clk);
      i_src_sel = SRC_ANALOG;
      host.cmd(DEV_TYPE, 8'h01, 8'h7f);
      expect_drive(P2, 0, 0);
      for (int k = 0; k < 3; k++) begin
         lvl = (k == 0) ? 10'h000 : (k == 1) ? 10'h3ff : 10'(rnd());
         @(negedge i_clk);
         i_cmd_level = lvl;
         c = int'(lvl) - 512;
         expect_drive(P2, c, 2 * mag(c));
      end
      lvl = {1'b1, 9'(rnd())};
      @(negedge i_clk);
      i_fb_mode = FB_POS;
      i_cmd_level = 10'h300;
      i_fb_level = lvl;
      c = 768 - int'(lvl);
      expect_drive(P2, c, 2 * mag(c));
      tx_byte_is({2'b01, lvl[9:4]});
      @(negedge i_clk);
      i_fb_mode = FB_SPEED;
      i_cmd_level = 10'h32c;
      host.tach_half = 10;
      repeat (3 * GATE) @(negedge i_clk);
      expect_drive(P2, 1, 400);
      host.tach_half = 2;
      repeat (3 * GATE) @(negedge i_clk);
      expect_drive(P2, 0, 0);
      @(negedge i_clk);
      i_rst_n = 1'b0;
      i_src_sel = SRC_SERIAL;
      i_fb_mode = FB_NONE;
      host.tach_half = 0;
      repeat (T_RST_MIN_NS / CLK_NS) @(negedge i_clk);
      i_rst_n = 1'b1;
      host.cmd(DEV_TYPE, 8'h01, 8'h40);
      expect_drive(P0, 1, 512);
      report_and_stop();
   end
   initial begin
      repeat (100000) @(posedge i_clk);
      check(0, 1);
      report_and_stop();
   end
endmodule
